// ### rtl/rgc_regs.vh
// Register offsets, field positions and reset values of the gain loop and
// synthesizer calibration register bank.
// Assumes inclusion by the bank and its gain loop, in one clock domain.
`ifndef RGC_REGS_VH
`define RGC_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RGC_OFF_GAIN_LOOP      6'h1D
`define RGC_OFF_RSVD_TUNE      6'h20
`define RGC_OFF_FRONT_END      6'h21
`define RGC_OFF_CAL_PUMP       6'h23
`define RGC_OFF_CAL_OSC        6'h24
`define RGC_OFF_CAL_COARSE     6'h25
`define RGC_OFF_CAL_CTRL       6'h26

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RGC_RST_GAIN_LOOP      8'h91
`define RGC_RST_RSVD_TUNE      8'hF8
`define RGC_RST_FRONT_END      8'h56
`define RGC_RST_CAL_PUMP       8'hA9
`define RGC_RST_CAL_OSC        8'h0A
`define RGC_RST_CAL_COARSE     8'h20
`define RGC_RST_CAL_CTRL       8'h0D

// ----------------------------------------------------------------------------
// Writable bit masks (unused bits read zero)
// ----------------------------------------------------------------------------
`define RGC_MSK_RSVD_TUNE      8'hFB
`define RGC_MSK_CAL_OSC        8'h3F
`define RGC_MSK_CAL_COARSE     8'h3F
`define RGC_MSK_CAL_CTRL       8'h7F

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RGC_HYST_MSB           7
`define RGC_HYST_LSB           6
`define RGC_WAIT_MSB           5
`define RGC_WAIT_LSB           4
`define RGC_FREEZE_MSB         3
`define RGC_FREEZE_LSB         2
`define RGC_FILT_MSB           1
`define RGC_FILT_LSB           0
`define RGC_PUMP_EN_MSB        5
`define RGC_PUMP_EN_LSB        4
`define RGC_PUMP_RES_MSB       3
`define RGC_PUMP_RES_LSB       0
`define RGC_HIGH_CORE_BIT      5
`define RGC_OSC_RES_MSB        4
`define RGC_OSC_RES_LSB        0
`define RGC_COARSE_MSB         5
`define RGC_COARSE_LSB         0
`define RGC_AMP_MSB            7
`define RGC_AMP_LSB            6
`define RGC_AMP_MIX_MSB        5
`define RGC_AMP_MIX_LSB        4
`define RGC_LO_BUF_MSB         3
`define RGC_LO_BUF_LSB         2
`define RGC_MIXER_MSB          1
`define RGC_MIXER_LSB          0
`define RGC_CTRL_MSB           6
`define RGC_CTRL_LSB           0

// ----------------------------------------------------------------------------
// Gain loop timing counts and OOK boundary values in dB
// ----------------------------------------------------------------------------
`define RGC_SKIP_BASE          6'h08
`define RGC_AVG_BASE           7'h08
`define RGC_OOK_BASE_DB        5'h04
`define RGC_RST_OOK_DB         5'h08

// ----------------------------------------------------------------------------
// Gain freeze modes
// ----------------------------------------------------------------------------
`define RGC_FRZ_NONE           2'h0
`define RGC_FRZ_ON_SYNC        2'h1
`define RGC_FRZ_ANALOG         2'h2
`define RGC_FRZ_ALL            2'h3

`endif

// ### rtl/rgc_gain_loop.v
// Gain loop sequencing: post-adjust wait, averaging count and freeze gating.
// Assumes a channel filter sample strobe and adjust requests on i_core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "rgc_regs.vh"

module rgc_gain_loop (
    input  wire       i_core_clk,
    input  wire       i_reset_n,
    input  wire [1:0] i_wait_sel,
    input  wire [1:0] i_freeze_mode,
    input  wire [1:0] i_filt_sel,
    input  wire       i_ook_mode,
    input  wire       i_rx_start,
    input  wire       i_sync_found,
    input  wire       i_sample_stb,
    input  wire       i_adjust_req,
    output reg        o_analog_adj,
    output reg        o_digital_adj,
    output reg        o_avg_done,
    output reg  [4:0] o_ook_bound_db
);

    // ------------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------------
    function [6:0] rgc_avg_len;
        input [1:0] sel;
        begin
            rgc_avg_len = `RGC_AVG_BASE << sel;
        end
    endfunction

    reg [5:0] skip_cnt;
    reg [6:0] acc_cnt;
    reg       sync_frozen;
    wire      analog_ok;
    wire      digital_ok;
    wire      adjusting;
    wire [5:0] skip_len;

    // Post-adjust skip: 8, 16, 24 or 32 samples
    assign skip_len = {1'b0, i_wait_sel, 3'h0} + `RGC_SKIP_BASE; // RULE2

    // Freeze policy per mode
    assign analog_ok  = (i_freeze_mode == `RGC_FRZ_NONE) ||                    // RULE3
                        ((i_freeze_mode == `RGC_FRZ_ON_SYNC) && !sync_frozen); // RULE4
    assign digital_ok = analog_ok || (i_freeze_mode == `RGC_FRZ_ANALOG);        // RULE5 RULE6
    assign adjusting  = i_adjust_req && (skip_cnt == 6'h00) && o_avg_done;

    // Sync-word freeze latch, released on RX restart; a sync in the same cycle wins
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync_frozen <= 1'b0;
        end else if (i_sync_found) begin
            sync_frozen <= 1'b1; // RULE4
        end else if (i_rx_start) begin
            sync_frozen <= 1'b0;
        end
    end

    // Wait, averaging and adjust strobes
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            skip_cnt       <= 6'h00;
            acc_cnt        <= 7'h00;
            o_avg_done     <= 1'b0;
            o_analog_adj   <= 1'b0;
            o_digital_adj  <= 1'b0;
            o_ook_bound_db <= `RGC_RST_OOK_DB;
        end else begin
            o_ook_bound_db <= {1'b0, i_filt_sel, 2'h0} + `RGC_OOK_BASE_DB; // RULE8
            o_analog_adj   <= adjusting && analog_ok;
            o_digital_adj  <= adjusting && digital_ok;
            if (adjusting && digital_ok) begin
                skip_cnt   <= skip_len; // RULE2
                acc_cnt    <= 7'h00;
                o_avg_done <= 1'b0;
            end else if (i_sample_stb) begin
                if (skip_cnt != 6'h00) begin
                    skip_cnt <= skip_cnt - 6'h01;
                end else if (!i_ook_mode && !o_avg_done) begin
                    if (acc_cnt + 7'h01 == rgc_avg_len(i_filt_sel)) begin
                        o_avg_done <= 1'b1; // RULE7
                    end else begin
                        acc_cnt <= acc_cnt + 7'h01;
                    end
                end else if (i_ook_mode) begin
                    o_avg_done <= 1'b1;
                end
            end
        end
    end

endmodule // rgc_gain_loop
`default_nettype wire

// ### rtl/rgc_bank.v
// Gain loop and synthesizer calibration configuration register bank.
// Assumes a serial port front end delivering byte reads and writes
// synchronous to i_core_clk, and a calibrator writing results back.
//
// How it works
// RULE1 - Bits 7:6 pick hysteresis, reset two
// RULE2 - Skip 8..32 samples after each adjustment
// RULE3 - Freeze code zero adjusts gain always
// RULE4 - Code one freezes gain after sync word
// RULE5 - Code two freezes analogue, digital still adjusts
// RULE6 - Code three freezes both, manual override
// RULE7 - FSK averages 8..64 samples by field
// RULE8 - OOK field picks 4..16 dB boundary
// RULE9 - Pump calibration stage skipped when zero
// RULE10 - Four-bit pump result, reset nine
// RULE11 - Bit five selects high oscillator core
// RULE12 - Five-bit oscillator current result, host overridable
// RULE13 - Six-bit coarse tune result, reset 0x20
// RULE14 - Seven-bit calibration control stored as written
// RULE15 - Four two-bit bias trims with resets
// RULE16 - Reserved byte resets 0xF8, bit two zero
// RULE17 - Unused bits read zero, writes ignored; pump register bits 7:6 are stored as written and read back, reset 0b10
// RULE18 - Fields read back last written or result
`timescale 1ns/1ps
`default_nettype none
`include "rgc_regs.vh"

module rgc_bank (
    input  wire       i_core_clk,
    input  wire       i_reset_n,
    // Register access port
    input  wire       i_reg_wr,
    input  wire       i_reg_rd,
    input  wire [5:0] i_reg_addr,
    input  wire [7:0] i_reg_wdata,
    output reg  [7:0] o_reg_rdata,
    output wire       o_reg_hit,
    // Calibration result write-back
    input  wire       i_cal_pump_wr,
    input  wire [3:0] i_cal_pump_val,
    input  wire       i_cal_osc_wr,
    input  wire [4:0] i_cal_osc_val,
    input  wire       i_cal_coarse_wr,
    input  wire [5:0] i_cal_coarse_val,
    // Receive path status
    input  wire       i_ook_mode,
    input  wire       i_rx_start,
    input  wire       i_sync_found,
    input  wire       i_sample_stb,
    input  wire       i_adjust_req,
    // Gain loop outputs
    output wire [1:0] o_gain_hysteresis_sel,
    output wire       o_analog_adj,
    output wire       o_digital_adj,
    output wire       o_avg_done,
    output wire [4:0] o_ook_bound_db,
    // Analog trims
    output wire [1:0] o_input_amp_bias,
    output wire [1:0] o_amp_to_mixer_bias,
    output wire [1:0] o_rx_local_osc_buffer_bias,
    output wire [1:0] o_mixer_bias,
    output wire       o_pump_cal_stage_skip,
    output wire [3:0] o_pump_current,
    output wire       o_high_osc_core_select,
    output wire [4:0] o_osc_current,
    output wire [5:0] o_coarse_tune,
    output wire [6:0] o_synth_cal_control,
    output wire [7:0] o_reserved_tuning_byte
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    reg [7:0] gain_loop_control;
    reg [7:0] reserved_tuning_byte;
    reg [7:0] front_end_bias_trims;
    reg [7:0] synth_cal_charge_pump;
    reg [7:0] synth_cal_osc_current;
    reg [7:0] synth_cal_coarse_tune;
    reg [7:0] synth_cal_control;

    // Address match helper
    function wr_hit;
        input       wr;
        input [5:0] addr;
        input [5:0] off;
        begin
            wr_hit = wr && (addr == off);
        end
    endfunction

    // Host writes with masking; calibrator result written after host
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gain_loop_control     <= `RGC_RST_GAIN_LOOP;  // RULE1 RULE18
            reserved_tuning_byte  <= `RGC_RST_RSVD_TUNE;  // RULE16
            front_end_bias_trims  <= `RGC_RST_FRONT_END;  // RULE15
            synth_cal_charge_pump <= `RGC_RST_CAL_PUMP;   // RULE10
            synth_cal_osc_current <= `RGC_RST_CAL_OSC;    // RULE12
            synth_cal_coarse_tune <= `RGC_RST_CAL_COARSE; // RULE13
            synth_cal_control     <= `RGC_RST_CAL_CTRL;   // RULE14
        end else begin
            if (wr_hit(i_reg_wr, i_reg_addr, `RGC_OFF_GAIN_LOOP)) begin
                gain_loop_control <= i_reg_wdata; // RULE18
            end
            if (wr_hit(i_reg_wr, i_reg_addr, `RGC_OFF_RSVD_TUNE)) begin
                reserved_tuning_byte <= i_reg_wdata & `RGC_MSK_RSVD_TUNE; // RULE16 RULE17
            end
            if (wr_hit(i_reg_wr, i_reg_addr, `RGC_OFF_FRONT_END)) begin
                front_end_bias_trims <= i_reg_wdata; // RULE15
            end
            if (wr_hit(i_reg_wr, i_reg_addr, `RGC_OFF_CAL_PUMP)) begin
                synth_cal_charge_pump <= i_reg_wdata;
            end
            if (i_cal_pump_wr) begin
                synth_cal_charge_pump[`RGC_PUMP_RES_MSB:`RGC_PUMP_RES_LSB] <= i_cal_pump_val; // RULE10
            end
            if (wr_hit(i_reg_wr, i_reg_addr, `RGC_OFF_CAL_OSC)) begin
                synth_cal_osc_current <= i_reg_wdata & `RGC_MSK_CAL_OSC; // RULE17
            end
            if (i_cal_osc_wr) begin
                synth_cal_osc_current[`RGC_OSC_RES_MSB:`RGC_OSC_RES_LSB] <= i_cal_osc_val; // RULE12
            end
            if (wr_hit(i_reg_wr, i_reg_addr, `RGC_OFF_CAL_COARSE)) begin
                synth_cal_coarse_tune <= i_reg_wdata & `RGC_MSK_CAL_COARSE; // RULE17
            end
            if (i_cal_coarse_wr) begin
                synth_cal_coarse_tune[`RGC_COARSE_MSB:`RGC_COARSE_LSB] <= i_cal_coarse_val; // RULE13
            end
            if (wr_hit(i_reg_wr, i_reg_addr, `RGC_OFF_CAL_CTRL)) begin
                synth_cal_control <= i_reg_wdata & `RGC_MSK_CAL_CTRL; // RULE14 RULE17
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    reg [7:0] next_rdata;
    reg       next_hit;

    // Combinational decode of the read mux
    always @* begin
        next_hit   = 1'b1;
        next_rdata = 8'h00;
        case (i_reg_addr)
            `RGC_OFF_GAIN_LOOP:  next_rdata = gain_loop_control;
            `RGC_OFF_RSVD_TUNE:  next_rdata = reserved_tuning_byte;
            `RGC_OFF_FRONT_END:  next_rdata = front_end_bias_trims;
            `RGC_OFF_CAL_PUMP:   next_rdata = synth_cal_charge_pump;
            `RGC_OFF_CAL_OSC:    next_rdata = synth_cal_osc_current;
            `RGC_OFF_CAL_COARSE: next_rdata = synth_cal_coarse_tune;
            `RGC_OFF_CAL_CTRL:   next_rdata = synth_cal_control;
            default: begin
                next_hit   = 1'b0;
                next_rdata = 8'h00;
            end
        endcase
    end

    assign o_reg_hit = next_hit;

    // Registered read data, captured on read strobe
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            o_reg_rdata <= next_rdata; // RULE18
        end
    end

    // ------------------------------------------------------------------------
    // Field outputs
    // ------------------------------------------------------------------------
    assign o_gain_hysteresis_sel      = gain_loop_control[`RGC_HYST_MSB:`RGC_HYST_LSB]; // RULE1
    assign o_input_amp_bias           = front_end_bias_trims[`RGC_AMP_MSB:`RGC_AMP_LSB]; // RULE15
    assign o_amp_to_mixer_bias        = front_end_bias_trims[`RGC_AMP_MIX_MSB:`RGC_AMP_MIX_LSB];
    assign o_rx_local_osc_buffer_bias = front_end_bias_trims[`RGC_LO_BUF_MSB:`RGC_LO_BUF_LSB];
    assign o_mixer_bias               = front_end_bias_trims[`RGC_MIXER_MSB:`RGC_MIXER_LSB];
    assign o_pump_cal_stage_skip      =
        (synth_cal_charge_pump[`RGC_PUMP_EN_MSB:`RGC_PUMP_EN_LSB] == 2'h0); // RULE9
    assign o_pump_current             =
        synth_cal_charge_pump[`RGC_PUMP_RES_MSB:`RGC_PUMP_RES_LSB]; // RULE10
    assign o_high_osc_core_select     = synth_cal_osc_current[`RGC_HIGH_CORE_BIT]; // RULE11
    assign o_osc_current              =
        synth_cal_osc_current[`RGC_OSC_RES_MSB:`RGC_OSC_RES_LSB]; // RULE12
    assign o_coarse_tune              = synth_cal_coarse_tune[`RGC_COARSE_MSB:`RGC_COARSE_LSB];
    assign o_synth_cal_control        = synth_cal_control[`RGC_CTRL_MSB:`RGC_CTRL_LSB]; // RULE14
    assign o_reserved_tuning_byte     = reserved_tuning_byte;

    // ------------------------------------------------------------------------
    // Gain loop sequencer
    // ------------------------------------------------------------------------
    rgc_gain_loop u_gain_loop (
        .i_core_clk     (i_core_clk),
        .i_reset_n      (i_reset_n),
        .i_wait_sel     (gain_loop_control[`RGC_WAIT_MSB:`RGC_WAIT_LSB]),
        .i_freeze_mode  (gain_loop_control[`RGC_FREEZE_MSB:`RGC_FREEZE_LSB]),
        .i_filt_sel     (gain_loop_control[`RGC_FILT_MSB:`RGC_FILT_LSB]),
        .i_ook_mode     (i_ook_mode),
        .i_rx_start     (i_rx_start),
        .i_sync_found   (i_sync_found),
        .i_sample_stb   (i_sample_stb),
        .i_adjust_req   (i_adjust_req),
        .o_analog_adj   (o_analog_adj),
        .o_digital_adj  (o_digital_adj),
        .o_avg_done     (o_avg_done),
        .o_ook_bound_db (o_ook_bound_db)
    );

endmodule // rgc_bank
`default_nettype wire

// ### verif/rgc_bank_properties.sv
// Concurrent checks on the ports of the gain loop and calibration bank.
// Assumes binding to rgc_bank, one clock domain, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rgc_bank_properties (
    input wire logic       i_core_clk,
    input wire logic       i_reset_n,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [5:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_reg_hit,
    input wire logic       i_cal_pump_wr,
    input wire logic [3:0] i_cal_pump_val,
    input wire logic       i_cal_osc_wr,
    input wire logic [4:0] i_cal_osc_val,
    input wire logic [1:0] o_gain_hysteresis_sel,
    input wire logic       o_analog_adj,
    input wire logic       o_digital_adj,
    input wire logic [4:0] o_ook_bound_db,
    input wire logic [1:0] o_input_amp_bias,
    input wire logic [1:0] o_mixer_bias,
    input wire logic [3:0] o_pump_current,
    input wire logic [4:0] o_osc_current
);
    // ------------------------------------------------------------------
    // Shadow of the gain loop control byte
    // ------------------------------------------------------------------
    logic [7:0] gain_shadow;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    // Follows host writes to the gain loop control byte
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            gain_shadow <= 8'h91;
        else if (i_reg_wr && i_reg_addr == 6'h1D)
            gain_shadow <= i_reg_wdata;
    end

    hit_decode_a: assert property (o_reg_hit == (i_reg_addr inside {6'h1D, 6'h20, 6'h21,
        6'h23, 6'h24, 6'h25, 6'h26})) else $error("hit flag wrong");
    unmapped_read_a: assert property (i_reg_rd && !o_reg_hit |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    bias_write_a: assert property (i_reg_wr && i_reg_addr == 6'h21 |=>
        {o_input_amp_bias, o_mixer_bias} == {$past(i_reg_wdata[7:6]), $past(i_reg_wdata[1:0])})
        else $error("bias trims not updated");
    hyst_write_a: assert property (i_reg_wr && i_reg_addr == 6'h1D |=>
        o_gain_hysteresis_sel == $past(i_reg_wdata[7:6])) else $error("hysteresis not updated");
    pump_result_a: assert property (i_cal_pump_wr |=> o_pump_current == $past(i_cal_pump_val))
        else $error("pump result not stored");
    osc_result_a: assert property (i_cal_osc_wr |=> o_osc_current == $past(i_cal_osc_val))
        else $error("osc result not stored");
    freeze_all_a: assert property (gain_shadow[3:2] == 2'h3 && $past(gain_shadow[3:2]) == 2'h3
        |-> !o_analog_adj && !o_digital_adj) else $error("step while fully frozen");
    freeze_analog_a: assert property (gain_shadow[3:2] == 2'h2 && $past(gain_shadow[3:2]) == 2'h2
        |-> !o_analog_adj) else $error("analog step while frozen");
    ook_bound_a: assert property ($past(gain_shadow[1:0]) == gain_shadow[1:0] &&
        $past(gain_shadow[1:0], 2) == gain_shadow[1:0]
        |-> o_ook_bound_db == {1'b0, gain_shadow[1:0], 2'b00} + 5'h04) else $error("bad bound");

    cover property (gain_shadow[3:2] == 2'h3 ##1 i_reg_wr);
    cover property (i_cal_pump_wr ##1 i_cal_osc_wr);
    cover property (i_reg_rd && !o_reg_hit);
endmodule // rgc_bank_properties
`default_nettype wire

// ### verif/rgc_host_model.sv
// Host microcontroller model: byte reads and writes on the register port.
// Assumes it is clocked by i_core_clk and drives only at falling edges.
`timescale 1ns/1ps
`default_nettype none
module rgc_host_model #(
    parameter logic [7:0] REC_CAL_CTRL = 8'h0D,
    parameter logic [7:0] REC_RSVD     = 8'hF8
) (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_reg_rdata,
    output var  logic       o_reg_wr,
    output var  logic       o_reg_rd,
    output var  logic [5:0] o_reg_addr,
    output var  logic [7:0] o_reg_wdata
);
    // Idle port at time zero
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 6'h00;
        o_reg_wdata = 8'h00;
    end

    // One byte write; bus shows inverse values once released
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        o_reg_wr = 1'b1;
        o_reg_addr = a;
        o_reg_wdata = d;
        @(negedge i_core_clk);
        o_reg_wr = 1'b0;
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
    endtask

    // One byte read; data taken a cycle after the strobe edge
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        o_reg_rd = 1'b1;
        o_reg_addr = a;
        @(negedge i_core_clk);
        o_reg_rd = 1'b0;
        o_reg_addr = ~a;
        d = i_reg_rdata;
    endtask

    // Recommended calibration control and reserved byte loads
    task automatic load_recommended;
        wr(6'h26, REC_CAL_CTRL);
        wr(6'h20, REC_RSVD);
    endtask
endmodule // rgc_host_model
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the gain loop and calibration register bank.
// Assumes the host model drives the register port at falling edges.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk, rst_n, wr, rd, hit, pw, ow, cw, ook, rxs, syn, stb, req;
    logic       an, dg, avg, skip, hcore;
    logic [5:0] addr, cv, coarse;
    logic [7:0] wd, rdat, v, rsvd;
    logic [3:0] pv, pcur;
    logic [4:0] ov, bnd, ocur;
    logic [1:0] hys, b0, b1, b2, b3;
    logic [6:0] cctl;
    int         error_cnt, tests_run, n, a0, d0;
    int         an_cnt = 0;
    int         dg_cnt = 0;
    logic [5:0] offs [7] = '{6'h1D, 6'h20, 6'h21, 6'h23, 6'h24, 6'h25, 6'h26};
    logic [7:0] rsts [7] = '{8'h91, 8'hF8, 8'h56, 8'hA9, 8'h0A, 8'h20, 8'h0D};
    logic [7:0] msks [7] = '{8'hFF, 8'hFB, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h7F};

    rgc_host_model host (.i_core_clk(clk), .i_reg_rdata(rdat), .o_reg_wr(wr), .o_reg_rd(rd),
        .o_reg_addr(addr), .o_reg_wdata(wd));
    rgc_bank DUT (.i_core_clk(clk), .i_reset_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_hit(hit),
        .i_cal_pump_wr(pw), .i_cal_pump_val(pv), .i_cal_osc_wr(ow), .i_cal_osc_val(ov),
        .i_cal_coarse_wr(cw), .i_cal_coarse_val(cv), .i_ook_mode(ook), .i_rx_start(rxs),
        .i_sync_found(syn), .i_sample_stb(stb), .i_adjust_req(req),
        .o_gain_hysteresis_sel(hys), .o_analog_adj(an), .o_digital_adj(dg), .o_avg_done(avg),
        .o_ook_bound_db(bnd), .o_input_amp_bias(b0), .o_amp_to_mixer_bias(b1),
        .o_rx_local_osc_buffer_bias(b2), .o_mixer_bias(b3), .o_pump_cal_stage_skip(skip),
        .o_pump_current(pcur), .o_high_osc_core_select(hcore), .o_osc_current(ocur),
        .o_coarse_tune(coarse), .o_synth_cal_control(cctl), .o_reserved_tuning_byte(rsvd));

    // Clock and step counters
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        an_cnt <= an_cnt + (an === 1'b1);
        dg_cnt <= dg_cnt + (dg === 1'b1);
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One-cycle strobe on a bench input
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    // One channel filter sample, then a settle cycle
    task automatic samp;
        pulse(stb);
        @(negedge clk);
    endtask

    initial begin
        {rst_n, pw, ow, cw, ook, rxs, syn, stb, req} = '0;
        {pv, ov, cv, error_cnt, tests_run} = '0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 7; i++) begin
            host.rd(offs[i], v);
            chk(v, rsts[i]);
            host.wr(offs[i], 8'hFF);
            host.rd(offs[i], v);
            chk(v, msks[i]);
        end
        chk({skip, hcore, coarse}, 8'h7F);
        chk({1'b0, cctl}, 8'h7F);
        chk(rsvd, 8'hFB);
        for (int i = 0; i < 7; i++) host.wr(offs[i], 8'h00);
        chk({7'h00, skip}, 8'h01);
        host.wr(6'h22, 8'h55);
        host.rd(6'h22, v);
        chk(v, 8'h00);
        host.wr(6'h24, 8'h20);
        chk({7'h00, hcore}, 8'h01);
        {pv, ov, cv} = {4'h5, 5'h13, 6'h2A};
        pulse(pw);
        pulse(ow);
        pulse(cw);
        host.rd(6'h23, v);
        chk(v, 8'h05);
        host.rd(6'h24, v);
        chk(v, 8'h33);
        host.rd(6'h25, v);
        chk(v, 8'h2A);
        host.wr(6'h21, 8'h1B);
        chk({b0, b1, b2, b3}, 8'h1B);
        host.load_recommended();
        ook = 1'b1;
        for (int f = 0; f < 4; f++) begin
            host.wr(6'h1D, {6'h00, f[1:0]});
            @(negedge clk);
            chk({3'h0, bnd}, 8'h04 + 8'(f * 4));
        end
        ook = 1'b0;
        host.wr(6'h1D, 8'h10);
        req = 1'b1;
        for (n = 0; n < 200 && an !== 1'b1 && dg !== 1'b1; n++) samp();
        req = 1'b0;
        for (n = 0; n < 100 && avg !== 1'b1; n++) samp();
        chk(8'(n), 8'd24);
        // Freeze codes 0..3, then code 1 again before any sync word
        for (int m = 0; m < 5; m++) begin
            host.wr(6'h1D, {4'h0, (m == 4) ? 2'h1 : m[1:0], 2'b00});
            pulse(rxs);
            if (m == 1) pulse(syn);
            {a0, d0} = {an_cnt, dg_cnt};
            req = 1'b1;
            repeat (80) samp();
            req = 1'b0;
            v = (m % 4 == 0) ? 8'h03 : (m == 2) ? 8'h01 : 8'h00;
            chk({6'h00, an_cnt > a0, dg_cnt > d0}, v);
        end
        final_report();
    end

    // Hang guard
    initial begin
        #5000000;
        error_cnt++;
        final_report();
    end
endmodule // testbench

bind rgc_bank rgc_bank_properties chk_i (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit),
    .i_cal_pump_wr(i_cal_pump_wr), .i_cal_pump_val(i_cal_pump_val),
    .i_cal_osc_wr(i_cal_osc_wr), .i_cal_osc_val(i_cal_osc_val),
    .o_gain_hysteresis_sel(o_gain_hysteresis_sel), .o_analog_adj(o_analog_adj),
    .o_digital_adj(o_digital_adj), .o_ook_bound_db(o_ook_bound_db),
    .o_input_amp_bias(o_input_amp_bias), .o_mixer_bias(o_mixer_bias),
    .o_pump_current(o_pump_current), .o_osc_current(o_osc_current));
`default_nettype wire
